// ---- sim/ppm_far_model.sv ----
`default_nettype none
module ppm_far_model (
    // Stimulus.
    input wire logic clk_i,
    input wire logic [9:0] pat_i,
    // Pads.
    input wire logic [8:0] out_i,
    input wire logic [8:0] oe_i,
    input wire logic [8:0] pu_i,
    output logic [8:0] pad_o,
    output logic [9:0] src_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_reg = 1'b0;
    logic [9:0] src_reg = '0;
    always @(posedge clk_i) begin
        flip_reg <= ~flip_reg;
        src_reg <= pat_i;
    end
    assign src_o = src_reg;
    // A floating pad without pull-up toggles, so a stale level never passes for a driven one.
    assign pad_o = (oe_i & out_i) | (~oe_i & (pu_i | {9{flip_reg}}));
endmodule
`default_nettype wire

// ---- sim/ppm_mux_assertions.sv ----
`default_nettype none
module ppm_mux_checker
    import ppm_pkg::*;
(
    // Control.
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic load_config_i,
    input wire logic [6:0] port_d_peripheral_enable_i,
    input wire logic [7:0] system_pin_select_i,
    input wire logic [6:0] port_d_pullup_control_i,
    input wire logic idle_drive_control_i,
    // Levels.
    input wire logic [6:0] port_d_dir_i,
    input wire logic second_can_transmit_i,
    input wire logic external_bus_active_i,
    input wire logic [6:0] port_d_pad_oe_o,
    input wire logic [6:0] port_d_pullup_o
);
    logic [6:0] per_reg, pu_reg;
    logic [7:0] sel_reg;
    logic drv_reg;
    logic [2:0] cnt_reg;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {per_reg, pu_reg, sel_reg, drv_reg} <= {PPM_D_PER_RESET, PPM_D_PULL_RESET,
                PPM_SEL_RESET, PPM_DRIVE_RESET};
            cnt_reg <= 3'h0;
        end else begin
            if (load_config_i) begin
                {per_reg, pu_reg, sel_reg, drv_reg} <= {port_d_peripheral_enable_i,
                    port_d_pullup_control_i, system_pin_select_i, idle_drive_control_i};
            end
            cnt_reg <= cnt_reg + {2'h0, cnt_reg != 3'h7};
        end
    end
    // The synchroniser holds the pads quiet for three edges, so checks start after that.
    wire ok = cnt_reg > 3'h2;
    wire cs = drv_reg | external_bus_active_i;
    wire rx = per_reg[1] & ~sel_reg[5];
    wire [6:0] x_oe = (~per_reg & port_d_dir_i) | (per_reg & {1'b1, {4{cs}}, sel_reg[5] & cs,
        sel_reg[4] ? cs : ~second_can_transmit_i});
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_reset_float: assert property (cnt_reg < 3'h3 |-> port_d_pad_oe_o == 7'h00)
        else $error("pad driven in reset");
    a_gpio_default: assert property (cnt_reg == 3'h3 |->
        port_d_pad_oe_o[5:0] == $past(port_d_dir_i[5:0])) else $error("pin not gpio");
    a_pin0_route: assert property (ok |-> port_d_pad_oe_o[0] == $past(x_oe[0]))
        else $error("pin0 enable wrong");
    a_pin1_route: assert property (ok |-> port_d_pad_oe_o[1] == $past(x_oe[1]))
        else $error("pin1 enable wrong");
    a_cs_idle_drive: assert property (ok |-> port_d_pad_oe_o[5:2] == $past(x_oe[5:2]))
        else $error("chip select enable wrong");
    a_serial_tx: assert property (ok |-> port_d_pad_oe_o[6] == $past(x_oe[6]))
        else $error("pin6 enable wrong");
    a_can_rx_pull: assert property (ok && $past(rx) |-> port_d_pullup_o[1]
        && !port_d_pad_oe_o[1]) else $error("receive pull wrong");
    a_pull_follow: assert property (ok && !$past(rx) |->
        port_d_pullup_o == $past(pu_reg)) else $error("pull wrong");
    c_cs_route: cover property (ok && per_reg[0] && sel_reg[4]);
    c_can_pair: cover property (ok && rx);
    c_load: cover property (ok && load_config_i);
endmodule
bind ppm_port_pin_function_mux ppm_mux_checker u_ppm_mux_checker (.*);
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
module testbench;
    import ppm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, reset_n_i = 1'b0, load_config_i = 1'b0, idle_drive_control_i = 1'b0;
    logic [7:0] system_pin_select_i = 8'h00;
    logic [6:0] port_d_peripheral_enable_i = '0, port_d_pullup_control_i = '0;
    logic [6:0] port_d_dir_i = '0, port_d_data_i = '0, port_d_pad_i, port_d_pad_o;
    logic [6:0] port_d_pad_oe_o, port_d_pullup_o, port_d_gpio_in_o;
    logic [1:0] port_e_peripheral_enable_i = '0, port_e_pullup_control_i = '0;
    logic [1:0] port_e_dir_i = '0, port_e_data_i = '0, port_e_pad_i, port_e_pad_o;
    logic [1:0] port_e_pad_oe_o, port_e_pullup_o, port_e_gpio_in_o;
    logic [3:0] chip_select_hi_i;
    logic second_can_transmit_i, chip_select_two_i, chip_select_three_i, external_bus_active_i;
    logic serial0_transmit_i, serial1_transmit_i, second_can_receive_o, serial0_receive_o;
    logic [9:0] pat = '0;
    int failures = 0, total_checks = 0, seed = 32'h63f7_8b4a;
    always #4 clk_i = ~clk_i;
    ppm_port_pin_function_mux u_ppm_port_pin_function_mux (.*);
    ppm_far_model u_ppm_far_model (.clk_i, .pat_i(pat), .out_i({port_e_pad_o, port_d_pad_o}),
        .oe_i({port_e_pad_oe_o, port_d_pad_oe_o}), .pu_i({port_e_pullup_o, port_d_pullup_o}),
        .pad_o({port_e_pad_i, port_d_pad_i}), .src_o({second_can_transmit_i, chip_select_two_i,
        chip_select_three_i, chip_select_hi_i, external_bus_active_i, serial0_transmit_i,
        serial1_transmit_i}));
    task automatic check(input string what, input logic [6:0] exp, seen);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [6:0] d_oe(input logic [6:0] per, input logic [7:0] sel,
        input logic cs);
        return (~per & port_d_dir_i) | (per & {1'b1, {4{cs}}, sel[5] & cs,
            sel[4] ? cs : ~second_can_transmit_i});
    endfunction
    task automatic cmp(input logic [6:0] per, pu, input logic [7:0] sel, input logic drv,
        input logic [1:0] pe, epu);
        logic [6:0] oe, o, pu_x, din;
        logic [1:0] eoe, eo, ein;
        logic fl;
        // The far model flips floating pads without pull-up each edge; the design sampled the previous level.
        fl = ~u_ppm_far_model.flip_reg;
        oe = d_oe(per, sel, drv | external_bus_active_i);
        o = (~per & port_d_data_i) | (per & {serial1_transmit_i, chip_select_hi_i,
            chip_select_three_i, sel[4] & chip_select_two_i});
        check("d_oe", oe, port_d_pad_oe_o);
        check("d_out", o & oe, port_d_pad_o & oe);
        pu_x = pu | {5'h00, per[1] & ~sel[5], 1'b0};
        din = (oe & o) | (~oe & (pu_x | {7{fl}}));
        eoe = (~pe & port_e_dir_i) | {1'b0, pe[0]};
        eo = (~pe & port_e_data_i) | (pe & {1'b0, serial0_transmit_i});
        ein = (eoe & eo) | (~eoe & (epu | {2{fl}}));
        check("d_pull", pu_x, port_d_pullup_o);
        check("e_oe", {5'h00, eoe}, {5'h00, port_e_pad_oe_o});
        check("e_out", {5'h00, eo & eoe}, {5'h00, port_e_pad_o & eoe});
        check("e_pull", {5'h00, epu}, {5'h00, port_e_pullup_o});
        check("d_in", ~per & din, port_d_gpio_in_o);
        check("e_in", {5'h00, ~pe & ein}, {5'h00, port_e_gpio_in_o});
        check("can_rx", {6'h00, (per[1] & ~sel[5]) ? din[1] : 1'b1},
            {6'h00, second_can_receive_o});
        check("ser0_rx", {6'h00, pe[1] ? ein[1] : 1'b1}, {6'h00, serial0_receive_o});
    endtask
    task automatic defaults(input string name);
        repeat (4) @(posedge clk_i);
        #1;
        cmp(PPM_D_PER_RESET, PPM_D_PULL_RESET, PPM_SEL_RESET, PPM_DRIVE_RESET,
            PPM_E_PER_RESET, PPM_E_PULL_RESET);
        $display("test %s done", name);
    endtask
    task automatic trial(input logic [6:0] per, input logic [7:0] sel, input logic drv);
        logic [6:0] pu;
        logic [1:0] pe, epu;
        pu = 7'($random(seed));
        {pe, epu} = 4'($random(seed));
        @(posedge clk_i);
        load_config_i <= 1'b1;
        port_d_peripheral_enable_i <= per;
        port_e_peripheral_enable_i <= pe;
        system_pin_select_i <= sel;
        idle_drive_control_i <= drv;
        port_d_pullup_control_i <= pu;
        port_e_pullup_control_i <= epu;
        {port_d_dir_i, port_d_data_i, port_e_dir_i, port_e_data_i} <= 18'($random(seed));
        pat <= 10'($random(seed));
        @(posedge clk_i);
        // Config changes without the strobe must be ignored.
        load_config_i <= 1'b0;
        port_d_peripheral_enable_i <= ~per;
        system_pin_select_i <= ~sel;
        idle_drive_control_i <= ~drv;
        port_d_pullup_control_i <= ~pu;
        repeat (3) @(posedge clk_i);
        #1;
        cmp(per, pu, sel, drv, pe, epu);
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        defaults("reset_defaults");
        trial(7'h7f, 8'h30, 1'b0);
        trial(7'h03, 8'h00, 1'b1);
        trial(7'h7f, 8'h30, 1'b1);
        for (int i = 0; i < 60; i++) begin
            trial(7'($random(seed)), 8'($random(seed)), 1'($random(seed)));
        end
        $display("test random_mux done");
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check("rst_oe", 7'h00, {port_e_pad_oe_o, port_d_pad_oe_o[4:0]});
        check("rst_oe_hi", 7'h00, {5'h00, port_d_pad_oe_o[6:5]});
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        defaults("mid_reset");
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- verilog/ppm_pin_cell.sv ----
`default_nettype none
module ppm_pin_cell (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Selection and sources.
    input wire logic periph_sel_i,
    input wire logic gpio_dir_i,
    input wire logic gpio_data_i,
    input wire logic periph_out_i,
    input wire logic periph_oe_i,
    input wire logic pull_en_i,
    // Registered pad controls.
    output logic pad_out_o,
    output logic pad_oe_o,
    output logic pad_pull_o
);
    // In GPIO mode the direction bit alone decides drive.
    wire logic out_next = periph_sel_i ? periph_out_i : gpio_data_i;
    wire logic oe_next = periph_sel_i ? periph_oe_i : gpio_dir_i;
    // Reset leaves the pad undriven, which makes GPIO an input and a chip select floating.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_out_o <= 1'b0;
            pad_oe_o <= 1'b0;
            pad_pull_o <= 1'b0;
        end else begin
            pad_out_o <= out_next;
            pad_oe_o <= oe_next;
            pad_pull_o <= pull_en_i;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/ppm_pkg.sv ----
`default_nettype none
package ppm_pkg;
    // Port D pins handled here: 0..6; port E pins: 0..1.
    localparam int PPM_D_PINS = 7;
    localparam int PPM_E_PINS = 2;
    localparam int PPM_CS_HI_PINS = 4;
    // Bit positions in the port D peripheral-enable control.
    localparam int PPM_PER_PIN0_BIT = 0;
    localparam int PPM_PER_PIN1_BIT = 1;
    localparam int PPM_PER_CS_LO_BIT = 2;
    localparam int PPM_PER_SER1_BIT = 6;
    // Bit positions in the system pin-select control.
    localparam int PPM_SEL_PIN0_BIT = 4;
    localparam int PPM_SEL_PIN1_BIT = 5;
    localparam int PPM_SEL_WIDTH = 8;
    // Port E serial pin positions.
    localparam int PPM_E_SER0_TX_BIT = 0;
    localparam int PPM_E_SER0_RX_BIT = 1;
    // Reset values.
    localparam logic [6:0] PPM_D_PER_RESET = 7'h40;
    localparam logic [1:0] PPM_E_PER_RESET = 2'h3;
    localparam logic [6:0] PPM_D_PULL_RESET = 7'h7f;
    localparam logic [1:0] PPM_E_PULL_RESET = 2'h3;
    localparam logic [7:0] PPM_SEL_RESET = 8'h00;
    localparam logic PPM_DRIVE_RESET = 1'b0;
    typedef enum logic {
        PPM_SRC_CAN,
        PPM_SRC_CHIP_SELECT
    } ppm_src_type;
endpackage
`default_nettype wire

// ---- verilog/ppm_port_pin_function_mux.sv ----
`default_nettype none
// Summary of operation
// - Each GPIO pin has its own direction.
// - Port D pin 0 GPIO, enable bit 0.
// - Select bit 4 picks CAN or chip select.
// - Port D pin 1 GPIO, enable bit 1.
// - Select bit 5 picks CAN or chip select.
// - CAN receive function keeps pull-up on.
// - Chip selects come from memory interface decode.
// - Drive-control bit decides idle tri-state.
// - Port D pins 2-5 reset to GPIO.
// - Clearing port D pull bit disables pull-up, except on pin 1 while it is the CAN receive.
// - Serial transmit pins reset to serial function.
// - Clearing port E pull bit disables pull-up.
module ppm_port_pin_function_mux
    import ppm_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Software control bits.
    input wire logic [PPM_D_PINS-1:0] port_d_peripheral_enable_i,
    input wire logic [PPM_E_PINS-1:0] port_e_peripheral_enable_i,
    input wire logic [PPM_SEL_WIDTH-1:0] system_pin_select_i,
    input wire logic [PPM_D_PINS-1:0] port_d_pullup_control_i,
    input wire logic [PPM_E_PINS-1:0] port_e_pullup_control_i,
    input wire logic idle_drive_control_i,
    input wire logic load_config_i,
    // General-purpose I/O data and direction.
    input wire logic [PPM_D_PINS-1:0] port_d_dir_i,
    input wire logic [PPM_D_PINS-1:0] port_d_data_i,
    input wire logic [PPM_E_PINS-1:0] port_e_dir_i,
    input wire logic [PPM_E_PINS-1:0] port_e_data_i,
    // Peripheral sources.
    input wire logic second_can_transmit_i,
    input wire logic chip_select_two_i,
    input wire logic chip_select_three_i,
    input wire logic [PPM_CS_HI_PINS-1:0] chip_select_hi_i,
    input wire logic external_bus_active_i,
    input wire logic serial0_transmit_i,
    input wire logic serial1_transmit_i,
    // Pads of port D.
    input wire logic [PPM_D_PINS-1:0] port_d_pad_i,
    output logic [PPM_D_PINS-1:0] port_d_pad_o,
    output logic [PPM_D_PINS-1:0] port_d_pad_oe_o,
    output logic [PPM_D_PINS-1:0] port_d_pullup_o,
    // Pads of port E.
    input wire logic [PPM_E_PINS-1:0] port_e_pad_i,
    output logic [PPM_E_PINS-1:0] port_e_pad_o,
    output logic [PPM_E_PINS-1:0] port_e_pad_oe_o,
    output logic [PPM_E_PINS-1:0] port_e_pullup_o,
    // Inputs back to the core.
    output logic second_can_receive_o,
    output logic serial0_receive_o,
    output logic [PPM_D_PINS-1:0] port_d_gpio_in_o,
    output logic [PPM_E_PINS-1:0] port_e_gpio_in_o
);
    logic rst_n;
    logic [PPM_D_PINS-1:0] d_per_reg;
    logic [PPM_E_PINS-1:0] e_per_reg;
    logic [PPM_SEL_WIDTH-1:0] sel_reg;
    logic [PPM_D_PINS-1:0] d_pull_reg;
    logic [PPM_E_PINS-1:0] e_pull_reg;
    logic drive_reg;
    ppm_src_type pin0_src;
    ppm_src_type pin1_src;

    ppm_rst_sync u_rst (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .reset_n_o(rst_n)
    );

    // Configuration is captured on a load strobe so the pads switch in one cycle.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            d_per_reg <= PPM_D_PER_RESET;
            e_per_reg <= PPM_E_PER_RESET;
            sel_reg <= PPM_SEL_RESET;
            d_pull_reg <= PPM_D_PULL_RESET;
            e_pull_reg <= PPM_E_PULL_RESET;
            drive_reg <= PPM_DRIVE_RESET;
        end else if (load_config_i) begin
            d_per_reg <= port_d_peripheral_enable_i;
            e_per_reg <= port_e_peripheral_enable_i;
            sel_reg <= system_pin_select_i;
            d_pull_reg <= port_d_pullup_control_i;
            e_pull_reg <= port_e_pullup_control_i;
            drive_reg <= idle_drive_control_i;
        end
    end

    assign pin0_src = sel_reg[PPM_SEL_PIN0_BIT] ? PPM_SRC_CHIP_SELECT : PPM_SRC_CAN;
    assign pin1_src = sel_reg[PPM_SEL_PIN1_BIT] ? PPM_SRC_CHIP_SELECT : PPM_SRC_CAN;

    // Chip selects float while the bus is idle unless the drive bit is set.
    wire logic cs_oe = external_bus_active_i | drive_reg;

    // Open-drain CAN transmit: drive only when pulling low.
    wire logic pin0_out = (pin0_src == PPM_SRC_CAN) ? 1'b0 : chip_select_two_i;
    wire logic pin0_oe = (pin0_src == PPM_SRC_CAN) ? ~second_can_transmit_i : cs_oe;
    wire logic pin1_out = chip_select_three_i;
    wire logic pin1_oe = (pin1_src == PPM_SRC_CAN) ? 1'b0 : cs_oe;

    wire logic [PPM_D_PINS-1:0] d_per_out;
    wire logic [PPM_D_PINS-1:0] d_per_oe;
    wire logic [PPM_D_PINS-1:0] d_pull;
    assign d_per_out = {serial1_transmit_i, chip_select_hi_i, pin1_out, pin0_out};
    assign d_per_oe = {1'b1, {PPM_CS_HI_PINS{cs_oe}}, pin1_oe, pin0_oe};
    // The CAN receive pull-up stays on whatever the pull register says.
    wire logic can_rx_pull = d_per_reg[PPM_PER_PIN1_BIT] & (pin1_src == PPM_SRC_CAN);
    assign d_pull = d_pull_reg | {{(PPM_D_PINS-2){1'b0}}, can_rx_pull, 1'b0};

    wire logic [PPM_E_PINS-1:0] e_per_out;
    wire logic [PPM_E_PINS-1:0] e_per_oe;
    assign e_per_out = {1'b0, serial0_transmit_i};
    assign e_per_oe = {1'b0, 1'b1};

    genvar g;
    generate
        for (g = 0; g < PPM_D_PINS; g++) begin : gen_d
            ppm_pin_cell u_cell (
                .clk_i(clk_i),
                .reset_n_i(rst_n),
                .periph_sel_i(d_per_reg[g]),
                .gpio_dir_i(port_d_dir_i[g]),
                .gpio_data_i(port_d_data_i[g]),
                .periph_out_i(d_per_out[g]),
                .periph_oe_i(d_per_oe[g]),
                .pull_en_i(d_pull[g]),
                .pad_out_o(port_d_pad_o[g]),
                .pad_oe_o(port_d_pad_oe_o[g]),
                .pad_pull_o(port_d_pullup_o[g])
            );
        end
        for (g = 0; g < PPM_E_PINS; g++) begin : gen_e
            ppm_pin_cell u_cell (
                .clk_i(clk_i),
                .reset_n_i(rst_n),
                .periph_sel_i(e_per_reg[g]),
                .gpio_dir_i(port_e_dir_i[g]),
                .gpio_data_i(port_e_data_i[g]),
                .periph_out_i(e_per_out[g]),
                .periph_oe_i(e_per_oe[g]),
                .pull_en_i(e_pull_reg[g]),
                .pad_out_o(port_e_pad_o[g]),
                .pad_oe_o(port_e_pad_oe_o[g]),
                .pad_pull_o(port_e_pullup_o[g])
            );
        end
    endgenerate

    // Pad inputs are routed back registered; a peripheral-owned pin reads zero as GPIO.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            second_can_receive_o <= 1'b1;
            serial0_receive_o <= 1'b1;
            port_d_gpio_in_o <= '0;
            port_e_gpio_in_o <= '0;
        end else begin
            second_can_receive_o <= (d_per_reg[PPM_PER_PIN1_BIT] && pin1_src == PPM_SRC_CAN)
                ? port_d_pad_i[PPM_PER_PIN1_BIT] : 1'b1;
            serial0_receive_o <= e_per_reg[PPM_E_SER0_RX_BIT]
                ? port_e_pad_i[PPM_E_SER0_RX_BIT] : 1'b1;
            port_d_gpio_in_o <= port_d_pad_i & ~d_per_reg;
            port_e_gpio_in_o <= port_e_pad_i & ~e_per_reg;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/ppm_rst_sync.sv ----
`default_nettype none
module ppm_rst_sync (
    // Clock and raw reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Released reset.
    output logic reset_n_o
);
    logic stage_reg;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage_reg <= 1'b0;
            reset_n_o <= 1'b0;
        end else begin
            stage_reg <= 1'b1;
            reset_n_o <= stage_reg;
        end
    end
endmodule
`default_nettype wire
